// [verilog/tpc_pkg.sv]
// constants and types for the timer pwm, single pulse and capture block
package tpc_pkg;
  localparam int          ADDR_W       = 5;
  localparam int          CNT_W        = 10;
  localparam int          COMPARE_P_VALUE_W       = 3;
  localparam logic [4:0]  OFS_CTRL0    = 5'h00;
  localparam logic [4:0]  OFS_CTRL1    = 5'h04;
  localparam logic [4:0]  OFS_COUNT    = 5'h08;
  localparam logic [4:0]  OFS_CMPA     = 5'h0C;
  localparam logic [4:0]  OFS_CMPP     = 5'h10;
  localparam logic [4:0]  OFS_FLAGS    = 5'h14;
  localparam int          B_EN         = 0;
  localparam int          B_PRE_LO     = 1;
  localparam int          B_PRE_HI     = 2;
  localparam int          B_CCLR       = 0;
  localparam int          B_DPX        = 1;
  localparam int          B_POL        = 2;
  localparam int          B_OC         = 3;
  localparam int          B_IO_LO      = 4;
  localparam int          B_IO_HI      = 5;
  localparam int          B_MODE_LO    = 6;
  localparam int          B_MODE_HI    = 7;
  localparam int          B_FLAG_A     = 0;
  localparam int          B_FLAG_P     = 1;
  localparam logic [10:0] PERIOD_FULL  = 11'h400;
  localparam logic [10:0] ONE11        = 11'h001;
  localparam logic [6:0]  STEP_ZERO    = 7'h00;
  localparam logic [5:0]  DIV_1        = 6'h00;
  localparam logic [5:0]  DIV_4        = 6'h03;
  localparam logic [5:0]  DIV_16       = 6'h0F;
  localparam logic [5:0]  DIV_64       = 6'h3F;
  localparam logic [1:0]  PF_INACTIVE  = 2'h0;
  localparam logic [1:0]  PF_ACTIVE    = 2'h1;
  localparam logic [1:0]  PF_PWM       = 2'h2;
  localparam logic [1:0]  PF_PULSE     = 2'h3;
  localparam logic [1:0]  CAP_RISE     = 2'h0;
  localparam logic [1:0]  CAP_FALL     = 2'h1;
  localparam logic [1:0]  CAP_BOTH     = 2'h2;
  localparam logic [1:0]  CAP_OFF      = 2'h3;

  typedef enum logic [1:0] {
    TPC_MODE_COMPARE = 2'b00,
    TPC_MODE_CAPTURE = 2'b01,
    TPC_MODE_PWM     = 2'b10,
    TPC_MODE_TIMER   = 2'b11
  } tpc_mode_type;

  typedef struct packed {
    logic               wait_n;
    logic [31:0]        rdata;
    logic               en;
    logic               en_d;
    logic [1:0]         presc;
    tpc_mode_type       mode;
    logic [1:0]         pfunc;
    logic               oc;
    logic               pol;
    logic               dpx;
    logic               cclr;
    logic [CNT_W-1:0]   compare_a_value;
    logic [COMPARE_P_VALUE_W-1:0]  compare_p_value;
    logic [CNT_W-1:0]   cnt;
    logic [5:0]         div;
    logic               tick;
    logic [2:0]         trig_s;
    logic               trig_f;
    logic [2:0]         cap_s;
    logic               cap_f;
    logic               flag_a;
    logic               flag_p;
    logic               pin;
    logic               pin_en;
  } tpc_state_type;
endpackage

// [verilog/tpc_timer.sv]
// timer core: pwm, single pulse and input capture with avalon-mm register slave
//
// Design decisions made here: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/100ps
module tpc_timer
  import tpc_pkg::*;
(
  input  wire logic              CORE_CLK,
  input  wire logic              NRST,
  input  wire logic [ADDR_W-1:0] AVS_ADDRESS,
  input  wire logic              AVS_READ,
  input  wire logic              AVS_WRITE,
  input  wire logic [31:0]       AVS_WRITEDATA,
  input  wire logic [3:0]        AVS_BYTEENABLE,
  output logic      [31:0]       AVS_READDATA,
  output logic                   AVS_WAITREQUEST,
  input  wire logic              TRIG_IN,
  input  wire logic              CAP_IN,
  output logic                   PWM_OUT,
  output logic                   PWM_OUT_EN,
  output logic                   FLAG_A,
  output logic                   FLAG_P
);

  tpc_state_type st;
  tpc_state_type next_st;

  logic        req;
  logic        wr_go;
  logic        lane0;
  logic        lane1;
  logic [10:0] cnt11;
  logic [10:0] a_val;
  logic [10:0] p_val;
  logic [10:0] per;
  logic [10:0] duty;
  logic        period_end;
  logic        a_hit;
  logic        p_hit;
  logic        pwm_active;
  logic        out_active;
  logic        trig_edge;
  logic        cap_rise;
  logic        cap_fall;
  logic        cap_evt;
  logic        en_rise;
  logic        is_pwm;
  logic        is_pulse;
  logic        is_cap;
  logic        clr_cnt;
  logic [5:0]  div_top;
  logic [31:0] rd_word;

  always_comb
  begin
    next_st = st;

    req   = AVS_READ | AVS_WRITE;
    // an access completes on the edge where waitrequest was low
    wr_go = AVS_WRITE & st.wait_n;
    lane0 = AVS_BYTEENABLE[0];
    lane1 = AVS_BYTEENABLE[1];

    is_pwm   = (st.mode == TPC_MODE_PWM) & (st.pfunc != PF_PULSE);
    is_pulse = (st.mode == TPC_MODE_PWM) & (st.pfunc == PF_PULSE);
    is_cap   = (st.mode == TPC_MODE_CAPTURE);
    en_rise  = st.en & ~st.en_d;

    // timer clock enable from the prescaler
    case (st.presc)
      2'h0:    div_top = DIV_1;
      2'h1:    div_top = DIV_4;
      2'h2:    div_top = DIV_16;
      2'h3:    div_top = DIV_64;
      default: div_top = DIV_1;
    endcase
    if (st.div >= div_top)
    begin
      next_st.div  = '0;
      next_st.tick = 1'b1;
    end
    else
    begin
      next_st.div  = st.div + 6'h01;
      next_st.tick = 1'b0;
    end

    // compare limits, zero encodes a full 1024-count span
    cnt11 = {1'b0, st.cnt};
    a_val = (st.compare_a_value == '0) ? PERIOD_FULL : {1'b0, st.compare_a_value};
    p_val = (st.compare_p_value == '0) ? PERIOD_FULL : {1'b0, st.compare_p_value, STEP_ZERO};
    if (st.dpx)
    begin
      per  = a_val;
      duty = p_val;
    end
    else
    begin
      per  = p_val;
      duty = {1'b0, st.compare_a_value};
    end
    // clear source select is never consulted in these modes
    period_end = (cnt11 == (per - ONE11));
    pwm_active = (duty >= per) | (cnt11 < duty);

    // comparator events qualified by the timer tick and enable
    a_hit = 1'b0;
    p_hit = 1'b0;
    if (st.tick & st.en & ~en_rise)
    begin
      if (is_pwm)
      begin
        a_hit = st.dpx ? period_end : (cnt11 == duty);
        p_hit = st.dpx ? (cnt11 == duty) : period_end;
      end
      else if (is_pulse)
      begin
        a_hit = (cnt11 == (a_val - ONE11));
      end
      else
      begin
        p_hit = (cnt11 == (p_val - ONE11));
        a_hit = ~is_cap & (cnt11 == (a_val - ONE11));
      end
    end

    // input synchronisers: a change counts once stages two and three agree
    next_st.trig_s = {st.trig_s[1:0], TRIG_IN};
    next_st.cap_s  = {st.cap_s[1:0], CAP_IN};
    if (st.trig_s[2] == st.trig_s[1])
    begin
      next_st.trig_f = st.trig_s[2];
    end
    if (st.cap_s[2] == st.cap_s[1])
    begin
      next_st.cap_f = st.cap_s[2];
    end
    trig_edge = next_st.trig_f & ~st.trig_f;
    cap_rise  = next_st.cap_f & ~st.cap_f;
    cap_fall  = ~next_st.cap_f & st.cap_f;
    case (st.pfunc)
      CAP_RISE: cap_evt = cap_rise;
      CAP_FALL: cap_evt = cap_fall;
      CAP_BOTH: cap_evt = cap_rise | cap_fall;
      CAP_OFF:  cap_evt = 1'b0;
      default:  cap_evt = 1'b0;
    endcase
    cap_evt = cap_evt & is_cap & st.en & ~en_rise;

    // register writes
    if (wr_go)
    begin
      case (AVS_ADDRESS)
        OFS_CTRL0:
        begin
          if (lane0)
          begin
            next_st.en    = AVS_WRITEDATA[B_EN];
            next_st.presc = AVS_WRITEDATA[B_PRE_HI:B_PRE_LO];
          end
        end
        OFS_CTRL1:
        begin
          if (lane0)
          begin
            next_st.mode  = tpc_mode_type'(AVS_WRITEDATA[B_MODE_HI:B_MODE_LO]);
            next_st.pfunc = AVS_WRITEDATA[B_IO_HI:B_IO_LO];
            next_st.oc    = AVS_WRITEDATA[B_OC];
            next_st.pol   = AVS_WRITEDATA[B_POL];
            next_st.dpx   = AVS_WRITEDATA[B_DPX];
            next_st.cclr  = AVS_WRITEDATA[B_CCLR];
          end
        end
        OFS_CMPA:
        begin
          if (lane0)
          begin
            next_st.compare_a_value[7:0] = AVS_WRITEDATA[7:0];
          end
          if (lane1)
          begin
            next_st.compare_a_value[CNT_W-1:8] = AVS_WRITEDATA[CNT_W-1:8];
          end
        end
        OFS_CMPP:
        begin
          if (lane0)
          begin
            next_st.compare_p_value = AVS_WRITEDATA[COMPARE_P_VALUE_W-1:0];
          end
        end
        OFS_FLAGS:
        begin
          if (lane0 & AVS_WRITEDATA[B_FLAG_A])
          begin
            next_st.flag_a = 1'b0;
          end
          if (lane0 & AVS_WRITEDATA[B_FLAG_P])
          begin
            next_st.flag_p = 1'b0;
          end
        end
        default:
        begin
          next_st.en = st.en;
        end
      endcase
    end

    // hardware control of the enable bit overrides a same-cycle write
    if (is_pulse & ~st.en & trig_edge)
    begin
      next_st.en = 1'b1;
    end
    if (is_pulse & a_hit)
    begin
      next_st.en = 1'b0;
    end

    // captured count overrides a same-cycle software write
    if (cap_evt)
    begin
      next_st.compare_a_value = st.cnt;
    end

    // sticky flags, a new event wins over a clear
    if (a_hit | cap_evt)
    begin
      next_st.flag_a = 1'b1;
    end
    if (p_hit)
    begin
      next_st.flag_p = 1'b1;
    end

    // counter: zeroed by enable rising, runs only while enabled
    clr_cnt = 1'b0;
    if (is_pwm)
    begin
      clr_cnt = period_end;
    end
    else if (~is_pulse)
    begin
      clr_cnt = st.cclr & ~is_cap ? (cnt11 == (a_val - ONE11)) : (cnt11 == (p_val - ONE11));
    end
    next_st.en_d = st.en;
    if (en_rise)
    begin
      next_st.cnt = '0;
    end
    else if (st.en & st.tick)
    begin
      // single pulse never wraps on a comparator
      next_st.cnt = clr_cnt ? '0 : st.cnt + 10'h001;
    end

    // output pin; the active level is picked by oc, then pol inverts
    out_active = 1'b0;
    if (is_pulse)
    begin
      // rises with the detected enable edge, falls with the clearing match
      out_active = st.en & next_st.en;
    end
    else if (is_pwm)
    begin
      case (st.pfunc)
        PF_INACTIVE: out_active = 1'b0;
        PF_ACTIVE:   out_active = 1'b1;
        PF_PWM:      out_active = st.en & ~en_rise & pwm_active;
        default:     out_active = 1'b0;
      endcase
    end
    if (st.mode == TPC_MODE_PWM)
    begin
      next_st.pin    = (out_active ? st.oc : ~st.oc) ^ st.pol;
      next_st.pin_en = 1'b1;
    end
    else
    begin
      // capture and other modes release the pin entirely
      next_st.pin    = 1'b0;
      next_st.pin_en = 1'b0;
    end

    // read mux; unmapped offsets read as zero
    rd_word = '0;
    case (AVS_ADDRESS)
      OFS_CTRL0:
      begin
        rd_word[B_EN]             = st.en;
        rd_word[B_PRE_HI:B_PRE_LO] = st.presc;
      end
      OFS_CTRL1:
      begin
        rd_word[B_MODE_HI:B_MODE_LO] = st.mode;
        rd_word[B_IO_HI:B_IO_LO]     = st.pfunc;
        rd_word[B_OC]                = st.oc;
        rd_word[B_POL]               = st.pol;
        rd_word[B_DPX]               = st.dpx;
        rd_word[B_CCLR]              = st.cclr;
      end
      OFS_COUNT: rd_word[CNT_W-1:0] = st.cnt;
      OFS_CMPA:  rd_word[CNT_W-1:0] = st.compare_a_value;
      OFS_CMPP:  rd_word[COMPARE_P_VALUE_W-1:0] = st.compare_p_value;
      OFS_FLAGS:
      begin
        rd_word[B_FLAG_A] = st.flag_a;
        rd_word[B_FLAG_P] = st.flag_p;
      end
      default:   rd_word = '0;
    endcase

    // one wait cycle per access keeps read data registered
    if (req & ~st.wait_n)
    begin
      next_st.wait_n = 1'b1;
      next_st.rdata  = rd_word;
    end
    else
    begin
      next_st.wait_n = 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign AVS_READDATA    = st.rdata;
  assign AVS_WAITREQUEST = ~st.wait_n;
  assign PWM_OUT         = st.pin;
  assign PWM_OUT_EN      = st.pin_en;
  assign FLAG_A          = st.flag_a;
  assign FLAG_P          = st.flag_p;

endmodule

// [tb/tpc_timer_asserts.sv]
// port assertions for the timer block
`timescale 1ns/100ps
module tpc_timer_chk
  import tpc_pkg::*;
(
  input wire logic              CORE_CLK,
  input wire logic              NRST,
  input wire logic [ADDR_W-1:0] AVS_ADDRESS,
  input wire logic              AVS_READ,
  input wire logic              AVS_WRITE,
  input wire logic [31:0]       AVS_READDATA,
  input wire logic              AVS_WAITREQUEST,
  input wire logic              PWM_OUT,
  input wire logic              PWM_OUT_EN,
  input wire logic              FLAG_A,
  input wire logic              FLAG_P
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!NRST);
  logic req;
  logic wdone;
  logic rdone;
  logic clr;
  assign req   = AVS_READ | AVS_WRITE;
  assign wdone = AVS_WRITE & ~AVS_WAITREQUEST;
  assign rdone = AVS_READ & ~AVS_WAITREQUEST;
  assign clr   = wdone & (AVS_ADDRESS == OFS_FLAGS);
  bus_answer_a: assert property (req && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
    else $error("no answer one cycle after a request");
  answer_short_a: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
    else $error("waitrequest low for more than one cycle");
  out_idle_a: assert property (!PWM_OUT_EN |-> !PWM_OUT)
    else $error("pin high while output disabled");
  en_steady_a: assert property (!wdone && !$past(wdone) |=> $stable(PWM_OUT_EN))
    else $error("output enable moved without a write");
  flag_a_hold_a: assert property (FLAG_A && !clr |=> FLAG_A)
    else $error("flag a dropped without a clear");
  flag_p_hold_a: assert property (FLAG_P && !clr |=> FLAG_P)
    else $error("flag p dropped without a clear");
  count_width_a: assert property (rdone && AVS_ADDRESS == OFS_COUNT |-> AVS_READDATA[31:10] == 22'h0)
    else $error("counter wider than ten bits");
  cmpa_width_a: assert property (rdone && AVS_ADDRESS == OFS_CMPA |-> AVS_READDATA[31:10] == 22'h0)
    else $error("compare a wider than ten bits");
  cover property ($rose(FLAG_A));
  cover property ($rose(FLAG_P));
  cover property ($rose(PWM_OUT));
endmodule

bind tpc_timer tpc_timer_chk u_chk (.CORE_CLK, .NRST, .AVS_ADDRESS, .AVS_READ, .AVS_WRITE,
  .AVS_READDATA, .AVS_WAITREQUEST, .PWM_OUT, .PWM_OUT_EN, .FLAG_A, .FLAG_P);

// [tb/tpc_pin_src.sv]
// far-side source for the trigger and capture pins
`timescale 1ns/100ps
module tpc_pin_src
(
  input wire logic CORE_CLK,
  output logic     TRIG_IN,
  output logic     CAP_IN
);
  initial
  begin
    TRIG_IN = 1'b0;
    CAP_IN  = 1'b0;
  end
  // levels held eight clocks so the input sync sees one clean edge
  task set_cap(input logic v);
    @(posedge CORE_CLK);
    CAP_IN <= v;
    repeat (7) @(posedge CORE_CLK);
  endtask
  // short pulse: returns before the pulse can start
  task trig_pulse;
    @(posedge CORE_CLK);
    TRIG_IN <= 1'b1;
    repeat (2) @(posedge CORE_CLK);
    TRIG_IN <= 1'b0;
  endtask
endmodule

// [tb/tb_timer_pwm_pulse_capture_modes.sv]
// self-checking bench for the pwm, single pulse and capture timer
`timescale 1ns/100ps
module tb_timer_pwm_pulse_capture_modes;
  import tpc_pkg::*;
  logic              CORE_CLK;
  logic              NRST;
  logic [ADDR_W-1:0] AVS_ADDRESS;
  logic              AVS_READ;
  logic              AVS_WRITE;
  logic [31:0]       AVS_WRITEDATA;
  logic [3:0]        AVS_BYTEENABLE;
  logic [3:0]        be;
  logic [31:0]       AVS_READDATA;
  logic              AVS_WAITREQUEST;
  logic              TRIG_IN;
  logic              CAP_IN;
  logic              PWM_OUT;
  logic              PWM_OUT_EN;
  logic              FLAG_A;
  logic              FLAG_P;
  logic [31:0]       q;
  logic [31:0]       q2;
  int                fails;
  int                checks;
  tpc_timer dut (.CORE_CLK, .NRST, .AVS_ADDRESS, .AVS_READ, .AVS_WRITE, .AVS_WRITEDATA,
    .AVS_BYTEENABLE, .AVS_READDATA, .AVS_WAITREQUEST, .TRIG_IN, .CAP_IN,
    .PWM_OUT, .PWM_OUT_EN, .FLAG_A, .FLAG_P);
  tpc_pin_src src (.CORE_CLK, .TRIG_IN, .CAP_IN);
  initial
  begin
    CORE_CLK = 1'b0;
    forever #25 CORE_CLK = ~CORE_CLK;
  end
  task tally_and_finish;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e)
    begin
      fails++;
      $display("ERROR %0t got %h exp %h", $time, g, e);
    end
  endtask
  task acc(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    int n;
    @(posedge CORE_CLK);
    AVS_ADDRESS   <= a;
    AVS_WRITEDATA <= d;
    AVS_BYTEENABLE <= be;
    AVS_WRITE     <= w;
    AVS_READ      <= !w;
    n = 0;
    do
    begin
      @(posedge CORE_CLK);
      n++;
    end
    while (AVS_WAITREQUEST !== 1'b0 && n < 20);
    q = AVS_READDATA;
    AVS_WRITE <= 1'b0;
    AVS_READ  <= 1'b0;
    if (n >= 20)
    begin
      fails++;
      tally_and_finish;
    end
  endtask
  // counts high cycles of the pin over a window
  task meas(input int pre, input int win, input int e);
    int h;
    h = 0;
    repeat (pre) @(posedge CORE_CLK);
    repeat (win)
    begin
      @(posedge CORE_CLK);
      h += int'(PWM_OUT === 1'b1);
    end
    chk(h, e);
  endtask
  task t_regs;
    for (int a = 0; a < 7; a++)
    begin
      acc(1'b0, 5'(a * 4), 32'h0);
      chk(q, 32'h0);
    end
    acc(1'b1, OFS_COUNT, 32'h3FF);
    acc(1'b0, OFS_COUNT, 32'h0);
    chk(q, 32'h0);
    acc(1'b1, OFS_CMPA, 32'hFFFF_FFFF);
    acc(1'b0, OFS_CMPA, 32'h0);
    chk(q, 32'h3FF);
    // low lane only: the top two compare bits must survive
    be = 4'h1;
    acc(1'b1, OFS_CMPA, 32'h0);
    be = 4'hF;
    acc(1'b0, OFS_CMPA, 32'h0);
    chk(q, 32'h300);
    $display("t_regs done");
  endtask
  task t_pwm;
    acc(1'b1, OFS_CMPP, 32'h1);
    acc(1'b1, OFS_CMPA, 32'h20);
    acc(1'b1, OFS_CTRL1, 32'hA9);
    acc(1'b1, OFS_CTRL0, 32'h1);
    meas(130, 256, 64);
    chk(FLAG_A, 1'h1);
    chk(FLAG_P, 1'h1);
    chk(PWM_OUT_EN, 1'h1);
    acc(1'b1, OFS_CTRL1, 32'hAD);
    meas(130, 256, 192);
    acc(1'b1, OFS_CTRL1, 32'hA1);
    meas(130, 256, 192);
    acc(1'b1, OFS_CTRL1, 32'h88);
    acc(1'b1, OFS_FLAGS, 32'h3);
    meas(130, 256, 0);
    chk(FLAG_P, 1'h1);
    acc(1'b1, OFS_CTRL1, 32'h98);
    meas(130, 256, 256);
    acc(1'b1, OFS_CMPA, 32'h80);
    acc(1'b1, OFS_CTRL1, 32'hA8);
    meas(130, 256, 256);
    acc(1'b1, OFS_CMPA, 32'h64);
    acc(1'b1, OFS_CTRL1, 32'hAA);
    meas(130, 256, 256);
    acc(1'b1, OFS_CMPP, 32'h0);
    acc(1'b1, OFS_CMPA, 32'h100);
    acc(1'b1, OFS_CTRL1, 32'hA8);
    meas(1100, 1024, 256);
    $display("t_pwm done");
  endtask
  task t_pulse;
    acc(1'b1, OFS_CTRL0, 32'h0);
    acc(1'b1, OFS_CTRL1, 32'hB8);
    acc(1'b1, OFS_CMPP, 32'h1);
    acc(1'b1, OFS_CMPA, 32'hC8);
    acc(1'b1, OFS_CTRL0, 32'h1);
    meas(0, 250, 200);
    acc(1'b0, OFS_CTRL0, 32'h0);
    chk(q, 32'h0);
    chk(FLAG_A, 1'h1);
    src.trig_pulse;
    meas(0, 250, 200);
    acc(1'b1, OFS_CMPA, 32'h0);
    acc(1'b1, OFS_CTRL0, 32'h1);
    meas(2, 40, 40);
    acc(1'b1, OFS_CTRL0, 32'h0);
    meas(2, 20, 0);
    $display("t_pulse done");
  endtask
  task t_cap;
    acc(1'b1, OFS_CMPP, 32'h0);
    for (int m = 0; m < 4; m++)
    begin
      acc(1'b1, OFS_CTRL1, 32'h40 | (m << 4));
      acc(1'b1, OFS_CTRL0, 32'h1);
      acc(1'b1, OFS_FLAGS, 32'h3);
      src.set_cap(1'b1);
      chk(FLAG_A, m == 0 || m == 2);
      acc(1'b1, OFS_FLAGS, 32'h3);
      src.set_cap(1'b0);
      chk(FLAG_A, m == 1 || m == 2);
      acc(1'b0, OFS_COUNT, 32'h0);
      q2 = q;
      acc(1'b0, OFS_COUNT, 32'h0);
      chk(q !== q2, 1'h1);
      chk(PWM_OUT_EN, 1'h0);
      acc(1'b1, OFS_CTRL0, 32'h0);
    end
    $display("t_cap done");
  endtask
  task t_span;
    acc(1'b1, OFS_CTRL1, 32'h40);
    acc(1'b1, OFS_CTRL0, 32'h1);
    src.set_cap(1'b1);
    src.set_cap(1'b0);
    acc(1'b0, OFS_CMPA, 32'h0);
    q2 = q;
    // bus read takes three edges, so rises land 300 clocks apart
    repeat (281) @(posedge CORE_CLK);
    src.set_cap(1'b1);
    src.set_cap(1'b0);
    acc(1'b0, OFS_CMPA, 32'h0);
    chk(q - q2, 32'h12C);
    acc(1'b1, OFS_CTRL0, 32'h0);
    acc(1'b1, OFS_CMPP, 32'h1);
    acc(1'b1, OFS_CTRL0, 32'h1);
    acc(1'b1, OFS_FLAGS, 32'h3);
    repeat (200) @(posedge CORE_CLK);
    chk(FLAG_P, 1'h1);
    acc(1'b0, OFS_COUNT, 32'h0);
    chk(q < 32'h80, 1'h1);
    acc(1'b1, OFS_CTRL0, 32'h0);
    acc(1'b0, OFS_COUNT, 32'h0);
    q2 = q;
    repeat (20) @(posedge CORE_CLK);
    acc(1'b0, OFS_COUNT, 32'h0);
    chk(q, q2);
    // prescaler: two reads 10 timer ticks apart differ by exactly ten
    acc(1'b1, OFS_CMPP, 32'h0);
    for (int p = 1; p < 4; p++)
    begin
      acc(1'b1, OFS_CTRL0, 32'(1 | (p << 1)));
      acc(1'b0, OFS_COUNT, 32'h0);
      q2 = q;
      repeat ((1 << (2 * p)) * 10 - 3) @(posedge CORE_CLK);
      acc(1'b0, OFS_COUNT, 32'h0);
      chk(q - q2, 32'h0000_000A);
    end
    acc(1'b1, OFS_CTRL0, 32'h0);
    $display("t_span done");
  endtask
  initial
  begin
    fails = 0;
    checks = 0;
    NRST = 1'b0;
    AVS_ADDRESS = '0;
    AVS_READ = 1'b0;
    AVS_WRITE = 1'b0;
    AVS_WRITEDATA = '0;
    AVS_BYTEENABLE = 4'hF;
    be = 4'hF;
    repeat (16) @(posedge CORE_CLK);
    NRST <= 1'b1;
    t_regs;
    t_pwm;
    t_pulse;
    t_cap;
    t_span;
    tally_and_finish;
  end
endmodule
